// ===== fil_loader.sv
// Purpose: Flash initialization loader, device end.
// Assumes: I_CLK at most 10 MHz in the real part; request synchronous to it.
// Notes: Flash content is an internal array; one clock of read then one write.
//        Each word takes two cycles: a fetch cycle that reads the array and
//        registers the data word, then a write cycle with the client strobe high.
//        The strobe pulses once per word rather than standing for a whole client
//        space. At most one strobe is ever high, and clients are never interleaved.
//        Client order is fixed by the package: analog, RAM, then custom clients.
//        The load-complete flag stays high until the loader reset is pulsed low,
//        and a request seen while it is high is ignored.
//        Save-back to flash is not built here; the link only carries loads.
//        A load cut by reset restarts from the first analog word.
//        Every client slot must be given a last address in the package.
`timescale 1ns/1ps
module fil_loader (
    input wire logic I_CLK, // Initialization clock
    input wire logic I_RESET_N, // Loader reset, active low
    fil_if.loader LNK // Client link
);
    typedef struct packed {
        fil_pkg::fil_state_e state;
        logic [fil_pkg::CLIENT_W-1:0] client;
        logic [fil_pkg::ADDR_W-1:0] addr;
        logic [fil_pkg::DATA_W-1:0] data;
        logic [fil_pkg::N_CLIENT-1:0] strobe;
        logic done;
    } fil_ld_s;

    fil_ld_s st_reg;
    fil_ld_s st_next;

    // Marks bit 8 of every simulated flash word, so that a client that keeps only
    // the low eight bits shows a different payload from one that keeps all nine.
    localparam logic [fil_pkg::DATA_W-1:0] FILL_MARK = 9'h100;

    // Whole partition image. Each client owns one 512-word slice, indexed by
    // client and address together, so no adder sits in the read path.
    logic [fil_pkg::DATA_W-1:0] flash_mem [fil_pkg::MEM_WORDS];
    logic [fil_pkg::MEM_IDX_W-1:0] rd_idx;
    logic [fil_pkg::DATA_W-1:0] rd_word;

    // Per-client decode of the current position.
    logic [fil_pkg::N_CLIENT-1:0] client_hit;
    logic [fil_pkg::N_CLIENT-1:0] client_end;

    // Sequencing terms shared by the state machine.
    logic start_load;
    logic last_word;
    logic last_client;
    logic [fil_pkg::ADDR_W-1:0] addr_step;
    logic [fil_pkg::CLIENT_W-1:0] client_step;

    // Nonvolatile content is preloaded by programming. In simulation each word holds
    // its own address with bit 8 set, which makes a misplaced or cut word visible.
    initial begin
        for (int i = 0; i < fil_pkg::MEM_WORDS; i++) begin
            flash_mem[i] = fil_pkg::DATA_W'(i) | FILL_MARK;
        end
    end

    // The read index comes from registered state only, so the word is stable for
    // the whole fetch cycle and no combinational path runs in from the link.
    assign rd_idx = fil_pkg::MEM_IDX_W'({st_reg.client, st_reg.addr});
    assign rd_word = flash_mem[rd_idx];

    // One decode slice per client. A client's space ends at its own last address,
    // so clients of different sizes share one address counter.
    for (genvar c = 0; c < fil_pkg::N_CLIENT; c++) begin : g_client
        assign client_hit[c] = (st_reg.client == fil_pkg::CLIENT_W'(c));
        assign client_end[c] = client_hit[c] && (st_reg.addr == fil_pkg::CLIENT_LAST[c]);
    end

    assign start_load = LNK.load_request && !st_reg.done;
    assign last_word = |client_end;
    assign last_client = client_hit[fil_pkg::N_CLIENT-1];
    assign addr_step = st_reg.addr + fil_pkg::ADDR_ONE;
    assign client_step = st_reg.client + fil_pkg::CLIENT_ONE;

    always_comb begin
        st_next = st_reg;
        case (st_reg.state)
            fil_pkg::FIL_IDLE: begin
                // start on request
                // A finished load is never repeated here; only a reset clears done.
                if (start_load) begin
                    st_next.client = '0;
                    st_next.addr = fil_pkg::ADDR_RESET;
                    st_next.state = fil_pkg::FIL_FETCH;
                end
            end
            fil_pkg::FIL_FETCH: begin
                st_next.data = rd_word;
                // strobe when writable
                // Data and strobe are registered on the same edge, and the address one edge
                // earlier, so a client never sees the strobe before its word has settled.
                st_next.strobe = client_hit;
                st_next.state = fil_pkg::FIL_WRITE;
            end
            fil_pkg::FIL_WRITE: begin
                st_next.strobe = '0;
                if (last_word) begin
                    // A new client always starts its space at address zero.
                    st_next.addr = fil_pkg::ADDR_RESET;
                    if (last_client) begin
                        st_next.done = 1'b1;
                        st_next.state = fil_pkg::FIL_DONE;
                    end else begin
                        st_next.client = client_step;
                        st_next.state = fil_pkg::FIL_FETCH;
                    end
                end else begin
                    st_next.addr = addr_step;
                    st_next.state = fil_pkg::FIL_FETCH;
                end
            end
            fil_pkg::FIL_DONE: begin
                // Address and data keep their last values; only the strobes matter.
                st_next.strobe = '0;
            end
            default: begin
                st_next.state = fil_pkg::FIL_IDLE;
            end
        endcase
    end

    // A reset in mid-load drops every strobe at once, so a client may keep a
    // partly written space; the following load rewrites it from the start.
    // rising edge of I_CLK
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            st_reg.state <= fil_pkg::FIL_IDLE;
            st_reg.client <= '0;
            st_reg.addr <= fil_pkg::ADDR_RESET;
            st_reg.data <= fil_pkg::DATA_RESET;
            st_reg.strobe <= '0;
            st_reg.done <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign LNK.load_done = st_reg.done;
    assign LNK.load_addr = st_reg.addr;
    assign LNK.load_data = st_reg.data;
    assign LNK.analog_wen = st_reg.strobe[fil_pkg::N_ANALOG-1:0];
    assign LNK.ram_load_valid = st_reg.strobe[fil_pkg::N_ANALOG+fil_pkg::N_RAM-1:fil_pkg::N_ANALOG];
    assign LNK.custom_sel = st_reg.strobe[fil_pkg::N_CLIENT-1:fil_pkg::N_ANALOG+fil_pkg::N_RAM];
endmodule

// ===== fil_pkg.sv
// Purpose: Shared constants and types for the flash initialization loader.
// Assumes: One initialization clock; client counts and sizes fixed here.
// Notes: Clients 0 and 1 are the analog subsystem, then RAM clients, then custom clients.
package fil_pkg;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 9;
    localparam int N_ANALOG = 2;
    localparam int N_RAM = 2;
    localparam int N_CUSTOM = 1;
    localparam int N_CLIENT = N_ANALOG + N_RAM + N_CUSTOM;
    localparam int CLIENT_W = 3;
    localparam int MEM_WORDS = N_CLIENT * 512;
    localparam int MEM_IDX_W = 12;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 9'h000;
    localparam logic [DATA_W-1:0] DATA_RESET = 9'h000;
    localparam logic [ADDR_W-1:0] ADDR_ONE = 9'h001;
    localparam logic [CLIENT_W-1:0] CLIENT_ONE = 3'h1;
    // Last address of each client space, client 0 first.
    localparam logic [ADDR_W-1:0] CLIENT_LAST [N_CLIENT] =
        '{9'h00f, 9'h01f, 9'h07f, 9'h03f, 9'h00f};
    localparam real CLK_MAX_MHZ = 10.0;
    typedef enum logic [1:0] {FIL_IDLE, FIL_FETCH, FIL_WRITE, FIL_DONE} fil_state_e;
endpackage

// ===== fil_if.sv
// Purpose: Link between the loader and its clients.
// Assumes: Both ends run on the initialization clock.
// Notes: Strobes are one bit per client, at most one high.
`timescale 1ns/1ps
interface fil_if;
    logic load_request;
    logic load_done;
    logic [fil_pkg::ADDR_W-1:0] load_addr;
    logic [fil_pkg::DATA_W-1:0] load_data;
    logic [fil_pkg::N_ANALOG-1:0] analog_wen;
    logic [fil_pkg::N_RAM-1:0] ram_load_valid;
    logic [fil_pkg::N_CUSTOM-1:0] custom_sel;
    modport loader (input load_request, output load_done, load_addr, load_data,
        analog_wen, ram_load_valid, custom_sel);
    modport client (output load_request, input load_done, load_addr, load_data,
        analog_wen, ram_load_valid, custom_sel);
endinterface

// ===== fil_client.sv
// Purpose: Client-side end: drives the request and captures written words.
// Assumes: Same clock as the loader.
// Notes: Presents the last captured word of any client and a single ready flag.
`timescale 1ns/1ps
module fil_client (
    input wire logic I_CLK, // Initialization clock
    input wire logic I_RESET_N, // System reset, active low
    input wire logic I_LOAD_ENABLE, // User wants loading
    input wire logic I_NINE_BIT_MODE, // Clients take nine bits when high
    fil_if.client LNK, // Loader link
    output logic O_CLIENTS_READY, // Clients may be accessed
    output logic [fil_pkg::ADDR_W-1:0] O_LAST_ADDR, // Last written address
    output logic [fil_pkg::DATA_W-1:0] O_LAST_DATA, // Last written payload
    output logic O_WRITE_SEEN // One cycle after any write
);
    typedef struct packed {
        logic req;
        logic ready;
        logic [fil_pkg::ADDR_W-1:0] addr;
        logic [fil_pkg::DATA_W-1:0] data;
        logic seen;
    } fil_cl_s;

    fil_cl_s st_reg;
    fil_cl_s st_next;
    logic any_strobe;

    assign any_strobe = (|LNK.analog_wen) | (|LNK.ram_load_valid) | (|LNK.custom_sel);

    always_comb begin
        st_next = st_reg;
        st_next.req = I_LOAD_ENABLE | (st_reg.req & !LNK.load_done);
        st_next.ready = LNK.load_done;
        st_next.seen = any_strobe;
        if (any_strobe) begin
            st_next.addr = LNK.load_addr;
            st_next.data = I_NINE_BIT_MODE ? LNK.load_data
                : {1'b0, LNK.load_data[fil_pkg::DATA_W-2:0]};
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            st_reg.req <= 1'b0;
            st_reg.ready <= 1'b0;
            st_reg.addr <= fil_pkg::ADDR_RESET;
            st_reg.data <= fil_pkg::DATA_RESET;
            st_reg.seen <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign LNK.load_request = st_reg.req;
    assign O_CLIENTS_READY = st_reg.ready;
    assign O_LAST_ADDR = st_reg.addr;
    assign O_LAST_DATA = st_reg.data;
    assign O_WRITE_SEEN = st_reg.seen;
endmodule

// ===== fil_asserts.sv
// Purpose: Link checks between loader and clients.
// Assumes: One clock, async active-low reset.
// Notes: Sees interface signals only.
`timescale 1ns/1ps
module fil_asserts (
    input wire logic I_CLK, // Clock
    input wire logic I_RESET_N, // Loader reset
    input wire logic load_request, // Request
    input wire logic load_done, // Done
    input wire logic [fil_pkg::ADDR_W-1:0] load_addr, // Address
    input wire logic [fil_pkg::DATA_W-1:0] load_data, // Data
    input wire logic [fil_pkg::N_ANALOG-1:0] analog_wen, // Analog strobes
    input wire logic [fil_pkg::N_RAM-1:0] ram_load_valid, // RAM valids
    input wire logic [fil_pkg::N_CUSTOM-1:0] custom_sel // Custom selects
);
    localparam logic [7:0] ANALOG_WORDS = 8'(fil_pkg::CLIENT_LAST[0]) +
        8'(fil_pkg::CLIENT_LAST[1]) + 8'h02;
    logic [fil_pkg::N_CLIENT-1:0] stb;
    logic [7:0] analog_cnt_reg;
    assign stb = {custom_sel, ram_load_valid, analog_wen};
    // Later clients are legal only once every analog word has gone out.
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            analog_cnt_reg <= 8'h00;
        end else if (|analog_wen) begin
            analog_cnt_reg <= analog_cnt_reg + 8'h01;
        end
    end
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);
    sequence s_word; |stb; endsequence
    sequence s_same_word; s_word ##2 (stb == $past(stb, 2)); endsequence
    property p_one_hot; $onehot0(stb); endproperty
    property p_rst_vals; $rose(I_RESET_N) |-> load_addr == 9'h000 && load_data == 9'h000
        && !load_done && stb == '0; endproperty
    property p_start; $rose(load_request) && !load_done |-> ##[1:2] analog_wen[0]
        && load_addr == fil_pkg::ADDR_RESET; endproperty
    property p_step; s_same_word |-> load_addr == $past(load_addr, 2) + fil_pkg::ADDR_ONE;
    endproperty
    property p_pulse; s_word |=> stb == '0; endproperty
    property p_order; (|ram_load_valid || |custom_sel) |-> analog_cnt_reg == ANALOG_WORDS;
    endproperty
    property p_done_rise; $rose(load_done) |-> $past(custom_sel[0])
        && $past(load_addr) == fil_pkg::CLIENT_LAST[fil_pkg::N_CLIENT-1]; endproperty
    property p_done_hold; load_done |=> load_done && stb == '0; endproperty
    a_one_hot: assert property (p_one_hot) else $error("two strobes high");
    a_rst_vals: assert property (p_rst_vals) else $error("bad reset values");
    a_start: assert property (p_start) else $error("load did not start");
    a_step: assert property (p_step) else $error("address did not step");
    a_pulse: assert property (p_pulse) else $error("strobe too long");
    a_order: assert property (p_order) else $error("analog not first");
    a_done_rise: assert property (p_done_rise) else $error("done early");
    a_done_hold: assert property (p_done_hold) else $error("done dropped");
endmodule

// ===== testbench.sv
// Purpose: Loader and client joined end to end.
// Assumes: Each flash word holds its own address with bit 8 set.
// Notes: Strobes are counted per client.
`timescale 1ns/1ps
module testbench;
    logic clk, ldr_rst_n, sys_rst_n, load_en, nine, ready, wr_seen;
    int wr_cnt;
    logic [8:0] last_addr, last_data;
    logic [4:0] stb;
    int errors, total_checks, cycles;
    int seen [fil_pkg::N_CLIENT];
    fil_if lnk ();
    fil_loader fil_loader_inst (.I_CLK(clk), .I_RESET_N(ldr_rst_n), .LNK(lnk));
    fil_client fil_client_inst (.I_CLK(clk), .I_RESET_N(sys_rst_n), .I_LOAD_ENABLE(load_en),
        .I_NINE_BIT_MODE(nine), .LNK(lnk), .O_CLIENTS_READY(ready),
        .O_LAST_ADDR(last_addr), .O_LAST_DATA(last_data), .O_WRITE_SEEN(wr_seen));
    fil_asserts fil_asserts_inst (.I_CLK(clk), .I_RESET_N(ldr_rst_n),
        .load_request(lnk.load_request), .load_done(lnk.load_done),
        .load_addr(lnk.load_addr), .load_data(lnk.load_data), .analog_wen(lnk.analog_wen),
        .ram_load_valid(lnk.ram_load_valid), .custom_sel(lnk.custom_sel));
    assign stb = {lnk.custom_sel, lnk.ram_load_valid, lnk.analog_wen};
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        for (int i = 0; i < fil_pkg::N_CLIENT; i++) if (stb[i] === 1'b1) seen[i]++;
        if (wr_seen === 1'b1) wr_cnt++;
        cycles++;
        if (cycles == 3000) begin
            errors++;
            wrap_up();
        end
    end
    task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic load_and_count(logic [15:0] exp_data);
        int n;
        int words;
        n = 0;
        words = 0;
        wr_cnt = 0;
        foreach (seen[i]) seen[i] = 0;
        while (lnk.load_done !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        @(posedge clk);
        #1;
        for (int i = 0; i < fil_pkg::N_CLIENT; i++) begin
            words += int'(fil_pkg::CLIENT_LAST[i]) + 1;
            chk("words", 16'(fil_pkg::CLIENT_LAST[i]) + 16'h1, 16'(seen[i]));
        end
        chk("write_seen", 16'(words), 16'(wr_cnt));
        chk("last_addr", 16'(fil_pkg::CLIENT_LAST[4]), 16'(last_addr));
        chk("last_data", exp_data, 16'(last_data));
    endtask
    task automatic t_idle();
        repeat (40) @(posedge clk);
        #1;
        chk("done", 16'h0000, 16'(lnk.load_done));
        chk("strobes", 16'h0000, 16'(seen[0] + seen[4]));
        chk("addr", 16'h0000, 16'(lnk.load_addr));
        chk("ready", 16'h0000, 16'(ready));
        $display("test idle finished");
    endtask
    task automatic t_load();
        @(posedge clk) load_en <= 1'b1;
        load_and_count(16'(fil_pkg::CLIENT_LAST[4]) | 16'h0100);
        repeat (30) @(posedge clk);
        #1;
        chk("ready", 16'h0001, 16'(ready));
        chk("late", 16'h0000, 16'(stb));
        $display("test load finished");
    endtask
    task automatic t_reload();
        @(posedge clk) ldr_rst_n <= 1'b0;
        nine <= 1'b0;
        @(posedge clk) ldr_rst_n <= 1'b1;
        #1;
        chk("done", 16'h0000, 16'(lnk.load_done));
        load_and_count(16'(fil_pkg::CLIENT_LAST[4]));
        $display("test reload finished");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        {ldr_rst_n, sys_rst_n, load_en, nine} = 4'h1;
        repeat (16) @(posedge clk);
        ldr_rst_n <= 1'b1;
        sys_rst_n <= 1'b1;
        t_idle();
        t_load();
        t_reload();
        wrap_up();
    end
endmodule
